//--- include/evc_pkg.sv
// Shared types and constants of the event counter.
// Assumes one 40 MHz clock and event pulses that last one clock cycle.
`default_nettype none

package evc_pkg;

    // Clock period and microsecond tick derived from it.
    localparam int CLK_PERIOD_NS  = 25;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Default width of the count, the limit and the held value.
    localparam int COUNT_WIDTH_DEFAULT = 32;

    // Event and signal sources shared by the increment, start and clear selects.
    typedef enum logic [3:0] {
        SRC_OFF,
        SRC_EXPOSURE_BEGIN,
        SRC_EXPOSURE_FINISH,
        SRC_READOUT_BEGIN,
        SRC_READOUT_FINISH,
        SRC_FRAME_BEGIN,
        SRC_ACCEPTED_TRIGGER,
        SRC_REJECTED_TRIGGER,
        SRC_BURST_END,
        SRC_LINK_TRIGGER,
        SRC_INPUT_LINE_A,
        SRC_INPUT_LINE_B,
        SRC_MICROSECOND_TICK,
        SRC_TIMER_DONE,
        SRC_COUNTER_DONE
    } evc_source_type;

    // Number of four-bit source codes, used to size the pulse vector.
    localparam int SOURCE_COUNT = 16;

    // Edge qualification for input lines.
    typedef enum logic [1:0] {
        EDGE_RISING,
        EDGE_FALLING,
        EDGE_ANY
    } evc_edge_type;

    // Counter states as software sees them.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_START,
        ST_ACTIVE,
        ST_COMPLETED
    } evc_state_type;

    // One-cycle event pulses from the acquisition logic and the timer.
    typedef struct packed {
        logic exposure_begin_event;
        logic exposure_finish_event;
        logic readout_begin_event;
        logic readout_finish_event;
        logic frame_begin_event;
        logic accepted_frame_trigger;
        logic rejected_frame_trigger;
        logic burst_end_event;
        logic timer_done_event;
    } evc_events_type;

    // Software settings of the counter.
    typedef struct packed {
        evc_source_type increment_source_select;
        evc_edge_type   increment_edge_select;
        evc_source_type start_source_select;
        evc_source_type clear_source_select;
    } evc_config_type;

endpackage

`default_nettype wire

//--- rtl/evc_edge_detect.sv
// Edge qualifier for a group of level signals.
// Assumes the levels are already synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none

module evc_edge_detect #(
    parameter int WIDTH = 3
) (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic [WIDTH-1:0]    level,
    input  wire evc_pkg::evc_edge_type edge_sel,
    output logic      [WIDTH-1:0]    qual_edge,
    output logic      [WIDTH-1:0]    any_edge
);

    // Refuse an empty group at elaboration.
    if (WIDTH < 1) begin : g_bad_width
        $error("evc_edge_detect: WIDTH must be at least one.");
    end

    logic [WIDTH-1:0] prev_reg;
    logic             primed_reg;

    // The first cycle after reset sees no edge, so a line high at reset does not count.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prev_reg   <= '0;
            primed_reg <= 1'b0;
        end else begin
            prev_reg   <= level;
            primed_reg <= 1'b1;
        end
    end

    // One pulse per qualifying edge, whatever the pulse width of the line.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            wire rise_w = primed_reg & level[i] & ~prev_reg[i];
            wire fall_w = primed_reg & ~level[i] & prev_reg[i];
            assign any_edge[i]  = rise_w | fall_w;
            assign qual_edge[i] = (edge_sel == evc_pkg::EDGE_RISING)  ? rise_w :
                                  (edge_sel == evc_pkg::EDGE_FALLING) ? fall_w :
                                  (edge_sel == evc_pkg::EDGE_ANY)     ? (rise_w | fall_w) :
                                  1'b0;
        end
    endgenerate

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // A falling qualification never fires while the line is high.
    property p_fall_only;
        (edge_sel == evc_pkg::EDGE_FALLING) |-> !(qual_edge[0] && level[0]);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("Falling edge fired on high line.");

    // A line held steady for two cycles gives no further pulse.
    property p_one_per_edge;
        qual_edge[0] ##1 $stable(level[0]) |-> !qual_edge[0];
    endproperty
    a_one_per_edge: assert property (p_one_per_edge) else $error("Edge counted twice.");

endmodule // evc_edge_detect

`default_nettype wire

//--- rtl/evc_counter.sv
// Event counter with selectable increment, start and clear sources.
// Assumes event inputs are one-cycle pulses and lines are synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none

module evc_counter #(
    parameter int COUNT_WIDTH = evc_pkg::COUNT_WIDTH_DEFAULT
) (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire evc_pkg::evc_events_type  events,
    input  wire logic                     link_trigger_in,
    input  wire logic                     input_line_a,
    input  wire logic                     input_line_b,
    input  wire evc_pkg::evc_config_type  config_in,
    input  wire logic [COUNT_WIDTH-1:0]   count_limit,
    input  wire logic                     clear_command,
    output logic      [COUNT_WIDTH-1:0]   count_value,
    output logic      [COUNT_WIDTH-1:0]   value_at_clear,
    output logic                          count_done_event,
    output evc_pkg::evc_state_type        counter_status
);

    // Refuse widths that the count logic cannot serve.
    if (COUNT_WIDTH < 2 || COUNT_WIDTH > 32) begin : g_bad_width
        $error("evc_counter: COUNT_WIDTH must lie between 2 and 32.");
    end

    localparam int TICK_W = $clog2(evc_pkg::TICK_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(evc_pkg::TICK_CYCLES - 1);

    evc_pkg::evc_state_type   state_reg;
    evc_pkg::evc_state_type   state_next;
    logic [COUNT_WIDTH-1:0]   count_reg;
    logic [COUNT_WIDTH-1:0]   count_next;
    logic [COUNT_WIDTH-1:0]   held_reg;
    logic                     done_reg;
    logic                     done_next;
    logic [TICK_W-1:0]        tick_cnt_reg;
    logic                     tick_reg;

    // Microsecond tick: one pulse every TICK_CYCLES clocks.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else begin
            tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0 : tick_cnt_reg + TICK_W'(1);
            tick_reg     <= (tick_cnt_reg == TICK_LAST);
        end
    end

    // Edge detection on the lines and the link trigger.
    logic [2:0] line_levels_w;
    logic [2:0] qual_edge_w;
    logic [2:0] any_edge_w;

    assign line_levels_w = {link_trigger_in, input_line_b, input_line_a};

    evc_edge_detect #(
        .WIDTH (3)
    ) u_edges (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .level     (line_levels_w),
        .edge_sel  (config_in.increment_edge_select),
        .qual_edge (qual_edge_w),
        .any_edge  (any_edge_w)
    );

    // Pulse vector indexed by source code; the off code never fires.
    logic [evc_pkg::SOURCE_COUNT-1:0] src_pulse_w;

    assign src_pulse_w[evc_pkg::SRC_OFF]              = 1'b0;
    assign src_pulse_w[evc_pkg::SRC_EXPOSURE_BEGIN]   = events.exposure_begin_event;
    assign src_pulse_w[evc_pkg::SRC_EXPOSURE_FINISH]  = events.exposure_finish_event;
    assign src_pulse_w[evc_pkg::SRC_READOUT_BEGIN]    = events.readout_begin_event;
    assign src_pulse_w[evc_pkg::SRC_READOUT_FINISH]   = events.readout_finish_event;
    assign src_pulse_w[evc_pkg::SRC_FRAME_BEGIN]      = events.frame_begin_event;
    assign src_pulse_w[evc_pkg::SRC_ACCEPTED_TRIGGER] = events.accepted_frame_trigger;
    assign src_pulse_w[evc_pkg::SRC_REJECTED_TRIGGER] = events.rejected_frame_trigger;
    assign src_pulse_w[evc_pkg::SRC_BURST_END]        = events.burst_end_event;
    assign src_pulse_w[evc_pkg::SRC_LINK_TRIGGER]     = any_edge_w[2];
    assign src_pulse_w[evc_pkg::SRC_INPUT_LINE_A]     = qual_edge_w[0];
    assign src_pulse_w[evc_pkg::SRC_INPUT_LINE_B]     = qual_edge_w[1];
    assign src_pulse_w[evc_pkg::SRC_MICROSECOND_TICK] = tick_reg;
    assign src_pulse_w[evc_pkg::SRC_TIMER_DONE]       = events.timer_done_event;
    assign src_pulse_w[evc_pkg::SRC_COUNTER_DONE]     = done_reg;
    assign src_pulse_w[15]                            = 1'b0;

    // Selection of the three event streams.
    wire inc_src_ok_w = (config_in.increment_source_select != evc_pkg::SRC_COUNTER_DONE);
    wire inc_hit_w    = inc_src_ok_w & src_pulse_w[config_in.increment_source_select];
    wire start_hit_w  = src_pulse_w[config_in.start_source_select];
    wire clear_hit_w  = clear_command | src_pulse_w[config_in.clear_source_select];
    wire start_off_w  = (config_in.start_source_select == evc_pkg::SRC_OFF);

    // Next count, saturating at the top of the range.
    wire [COUNT_WIDTH-1:0] count_inc_w = count_reg + COUNT_WIDTH'(1);
    wire                   count_max_w = &count_reg;
    wire                   limit_hit_w = (count_inc_w == count_limit);

    // Counter state machine; a clear wins over a start and an increment.
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        done_next  = 1'b0;
        if (clear_hit_w) begin
            count_next = '0;
            state_next = start_off_w ? evc_pkg::ST_IDLE : evc_pkg::ST_WAIT_START;
        end else begin
            unique case (state_reg)
                evc_pkg::ST_IDLE: begin
                    if (!start_off_w) begin
                        state_next = evc_pkg::ST_WAIT_START;
                    end
                end
                evc_pkg::ST_WAIT_START, evc_pkg::ST_COMPLETED: begin
                    if (start_off_w) begin
                        state_next = evc_pkg::ST_IDLE;
                    end else if (start_hit_w) begin
                        count_next = '0;
                        state_next = evc_pkg::ST_ACTIVE;
                    end
                end
                evc_pkg::ST_ACTIVE: begin
                    if (start_off_w) begin
                        state_next = evc_pkg::ST_IDLE;
                    end else if (inc_hit_w && !count_max_w) begin
                        count_next = count_inc_w;
                        if (limit_hit_w) begin
                            done_next  = 1'b1;
                            state_next = evc_pkg::ST_COMPLETED;
                        end
                    end
                end
            endcase
        end
    end

    // State, count, done pulse and the value caught at each clear.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= evc_pkg::ST_IDLE;
            count_reg <= '0;
            held_reg  <= '0;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            done_reg  <= done_next;
            if (clear_hit_w) begin
                held_reg <= count_reg;
            end
        end
    end

    assign count_value      = count_reg;
    assign value_at_clear   = held_reg;
    assign count_done_event = done_reg;
    assign counter_status   = state_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // No source selected leaves the count unchanged.
    property p_off_no_inc;
        (config_in.increment_source_select == evc_pkg::SRC_OFF) && !clear_hit_w && !start_hit_w
            |=> $stable(count_value);
    endproperty
    a_off_no_inc: assert property (p_off_no_inc) else $error("Count moved with no source.");

    // A selected event in the active state adds exactly one.
    property p_inc_one;
        (state_reg == evc_pkg::ST_ACTIVE) && inc_hit_w && !clear_hit_w && !start_off_w
            && !count_max_w |=> count_value == $past(count_value) + COUNT_WIDTH'(1);
    endproperty
    a_inc_one: assert property (p_inc_one) else $error("Increment was not one.");

    // Reaching the limit gives one done pulse and the completed state.
    property p_done_at_limit;
        (state_reg == evc_pkg::ST_ACTIVE) && inc_hit_w && limit_hit_w && !count_max_w
            && !clear_hit_w && !start_off_w
            |=> count_done_event && (counter_status == evc_pkg::ST_COMPLETED) ##1 !count_done_event;
    endproperty
    a_done_at_limit: assert property (p_done_at_limit) else $error("No done at limit.");

    // Done never rises without the count equal to the limit.
    property p_done_cause;
        $rose(count_done_event) |-> count_value == count_limit;
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("Done without limit.");

    // A start from waiting or completed begins at zero.
    property p_start_zero;
        ((state_reg == evc_pkg::ST_WAIT_START) || (state_reg == evc_pkg::ST_COMPLETED))
            && start_hit_w && !clear_hit_w && !start_off_w
            |=> (count_value == '0) && (counter_status == evc_pkg::ST_ACTIVE);
    endproperty
    a_start_zero: assert property (p_start_zero) else $error("Start did not zero.");

    // Every clear keeps the old count and parks the counter.
    property p_clear_hold;
        clear_hit_w |=> (value_at_clear == $past(count_value)) && (count_value == '0)
            && (counter_status != evc_pkg::ST_ACTIVE);
    endproperty
    a_clear_hold: assert property (p_clear_hold) else $error("Clear did not capture.");

    // Without a clear source only the command clears.
    property p_cmd_only;
        (config_in.clear_source_select == evc_pkg::SRC_OFF) && !clear_command
            |=> $stable(value_at_clear);
    endproperty
    a_cmd_only: assert property (p_cmd_only) else $error("Clear without command.");

    // After a clear nothing counts until a start arrives.
    property p_wait_start;
        clear_hit_w ##1 !start_hit_w |=> counter_status != evc_pkg::ST_ACTIVE;
    endproperty
    a_wait_start: assert property (p_wait_start) else $error("Active without start.");

    // Completed count holds until a clear or a new start.
    property p_hold_done;
        (state_reg == evc_pkg::ST_COMPLETED) && !clear_hit_w && !start_hit_w
            |=> $stable(count_value);
    endproperty
    a_hold_done: assert property (p_hold_done) else $error("Count moved after limit.");

    // Ticks are spaced at least nine cycles apart.
    property p_tick_space;
        tick_reg |=> !tick_reg [*8];
    endproperty
    a_tick_space: assert property (p_tick_space) else $error("Tick too soon.");

    // The tick arrives within one microsecond of the last one.
    property p_tick_due;
        tick_reg |=> ##[0:39] tick_reg;
    endproperty
    a_tick_due: assert property (p_tick_due) else $error("Tick overdue.");

    // An unset start source parks the counter in idle.
    property p_off_idle;
        start_off_w |=> counter_status == evc_pkg::ST_IDLE;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("Not idle without start.");

    // Idle never counts; only a clear touches the count.
    property p_idle_hold;
        (state_reg == evc_pkg::ST_IDLE) && !clear_hit_w |=> $stable(count_value);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("Count moved in idle.");

    // Waiting for start neither counts nor activates.
    property p_wait_no_inc;
        (state_reg == evc_pkg::ST_WAIT_START) && !start_hit_w && !clear_hit_w
            |=> $stable(count_value) && (counter_status != evc_pkg::ST_ACTIVE);
    endproperty
    a_wait_no_inc: assert property (p_wait_no_inc) else $error("Counted before start.");

    // At all ones the count saturates instead of wrapping.
    property p_sat_hold;
        (state_reg == evc_pkg::ST_ACTIVE) && count_max_w && !clear_hit_w
            |=> $stable(count_value);
    endproperty
    a_sat_hold: assert property (p_sat_hold) else $error("Count wrapped.");

    // The done event lasts a single cycle.
    property p_done_single;
        count_done_event |=> !count_done_event;
    endproperty
    a_done_single: assert property (p_done_single) else $error("Done held.");

    // The own done event clears when chosen as clear source.
    property p_self_clear;
        (config_in.clear_source_select == evc_pkg::SRC_COUNTER_DONE) && count_done_event
            |=> (count_value == '0) && (counter_status != evc_pkg::ST_ACTIVE);
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("Own done did not clear.");

endmodule // evc_counter

`default_nettype wire

//--- dv/evc_source_model.sv
// Behavioural model of the acquisition event sources, link trigger and input lines.
// Assumes the bench raises fire_valid just after a rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none

module evc_source_model (
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    fire_valid,
    input  wire evc_pkg::evc_source_type fire_src,
    input  wire logic                    fire_level,
    output evc_pkg::evc_events_type      events,
    output logic                         link_trigger_in,
    output logic                         input_line_a,
    output logic                         input_line_b
);
    // Start quiet so the counter never sees an unknown source at time zero.
    initial begin
        events = '0;
        link_trigger_in = 1'b0;
        input_line_a = 1'b0;
        input_line_b = 1'b0;
    end

    // Event pulses last one cycle, the link toggles per request, lines follow the level.
    always @(posedge ref_clk) begin
        events <= '0;
        if (sys_rst) begin
            link_trigger_in <= 1'b0;
            input_line_a <= 1'b0;
            input_line_b <= 1'b0;
        end else if (fire_valid) begin
            case (fire_src)
                evc_pkg::SRC_EXPOSURE_BEGIN:   events.exposure_begin_event <= 1'b1;
                evc_pkg::SRC_EXPOSURE_FINISH:  events.exposure_finish_event <= 1'b1;
                evc_pkg::SRC_READOUT_BEGIN:    events.readout_begin_event <= 1'b1;
                evc_pkg::SRC_READOUT_FINISH:   events.readout_finish_event <= 1'b1;
                evc_pkg::SRC_FRAME_BEGIN:      events.frame_begin_event <= 1'b1;
                evc_pkg::SRC_ACCEPTED_TRIGGER: events.accepted_frame_trigger <= 1'b1;
                evc_pkg::SRC_REJECTED_TRIGGER: events.rejected_frame_trigger <= 1'b1;
                evc_pkg::SRC_BURST_END:        events.burst_end_event <= 1'b1;
                evc_pkg::SRC_TIMER_DONE:       events.timer_done_event <= 1'b1;
                evc_pkg::SRC_LINK_TRIGGER:     link_trigger_in <= ~link_trigger_in;
                evc_pkg::SRC_INPUT_LINE_A:     input_line_a <= fire_level;
                evc_pkg::SRC_INPUT_LINE_B:     input_line_b <= fire_level;
                default: ;
            endcase
        end
    end
endmodule // evc_source_model

`default_nettype wire

//--- dv/evc_counter_tb_top.sv
// Self-checking bench of the event counter with an event source model.
// Assumes a 40 MHz ref_clk and an eight-bit count to keep runs short.
`timescale 1ns/100ps
`default_nettype none

module evc_counter_tb_top;
    localparam int CW = 8;
    logic                    ref_clk = 1'b0;
    logic                    sys_rst = 1'b1;
    logic                    fire_valid = 1'b0;
    evc_pkg::evc_source_type fire_src = evc_pkg::SRC_OFF;
    logic                    fire_level = 1'b0;
    evc_pkg::evc_config_type config_in = '0;
    logic [CW-1:0]           count_limit = 8'h00;
    logic                    clear_command = 1'b0;
    evc_pkg::evc_events_type events;
    logic                    link_trigger_in;
    logic                    input_line_a;
    logic                    input_line_b;
    logic [CW-1:0]           count_value;
    logic [CW-1:0]           value_at_clear;
    logic                    count_done_event;
    evc_pkg::evc_state_type  counter_status;
    int                      num_errors = 0;
    int                      num_checks = 0;
    int                      done_seen = 0;

    // Clock generation at 25 ns.
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Count done pulses so completion is seen exactly once.
    always @(posedge ref_clk) begin
        if (count_done_event === 1'b1) done_seen <= done_seen + 1;
    end

    // Far side and device under test.
    evc_source_model src (.ref_clk(ref_clk), .sys_rst(sys_rst), .fire_valid(fire_valid),
        .fire_src(fire_src), .fire_level(fire_level), .events(events),
        .link_trigger_in(link_trigger_in), .input_line_a(input_line_a),
        .input_line_b(input_line_b));
    evc_counter #(.COUNT_WIDTH(CW)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .events(events),
        .link_trigger_in(link_trigger_in), .input_line_a(input_line_a),
        .input_line_b(input_line_b), .config_in(config_in), .count_limit(count_limit),
        .clear_command(clear_command), .count_value(count_value),
        .value_at_clear(value_at_clear), .count_done_event(count_done_event),
        .counter_status(counter_status));

    // Closing report and end of run.
    task automatic results();
        if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Compares one value and reports a mismatch.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Lets n edges pass and settles just after the last.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Requests n back-to-back occurrences; the counter has acted on return.
    task automatic fire(input evc_pkg::evc_source_type s, input logic lvl, input int n);
        @(posedge ref_clk);
        fire_valid <= 1'b1;
        fire_src <= s;
        fire_level <= lvl;
        repeat (n) @(posedge ref_clk);
        fire_valid <= 1'b0;
        tick(1);
    endtask

    // Configures, clears by command and starts the counter.
    task automatic restart(input evc_pkg::evc_source_type inc, input evc_pkg::evc_edge_type edg,
                           input evc_pkg::evc_source_type st, input evc_pkg::evc_source_type clr,
                           input logic [7:0] lim);
        @(posedge ref_clk);
        config_in <= '{inc, edg, st, clr};
        count_limit <= lim;
        @(posedge ref_clk);
        clear_command <= 1'b1;
        @(posedge ref_clk);
        clear_command <= 1'b0;
        tick(1);
        fire(st, 1'b0, 1);
    endtask

    // A disabled increment source leaves a started counter at zero.
    task automatic t_off();
        restart(evc_pkg::SRC_OFF, evc_pkg::EDGE_RISING, evc_pkg::SRC_FRAME_BEGIN,
                evc_pkg::SRC_OFF, 8'h05);
        fire(evc_pkg::SRC_EXPOSURE_BEGIN, 1'b0, 2);
        fire(evc_pkg::SRC_LINK_TRIGGER, 1'b0, 2);
        chk({6'h00, counter_status}, 8'h02);
        chk(count_value, 8'h00);
    endtask

    // Each event source and the link count back to back up to the limit, then hold; frame begin restarts at zero.
    task automatic t_inc_loop();
        evc_pkg::evc_source_type lst[10] = '{evc_pkg::SRC_EXPOSURE_BEGIN,
            evc_pkg::SRC_EXPOSURE_FINISH, evc_pkg::SRC_READOUT_BEGIN,
            evc_pkg::SRC_READOUT_FINISH, evc_pkg::SRC_FRAME_BEGIN, evc_pkg::SRC_ACCEPTED_TRIGGER,
            evc_pkg::SRC_REJECTED_TRIGGER, evc_pkg::SRC_BURST_END, evc_pkg::SRC_LINK_TRIGGER,
            evc_pkg::SRC_TIMER_DONE};
        int d0;
        foreach (lst[i]) begin
            restart(lst[i], evc_pkg::EDGE_RISING, evc_pkg::SRC_FRAME_BEGIN,
                    evc_pkg::SRC_OFF, 8'h03);
            d0 = done_seen;
            fire(lst[i], 1'b0, 3);
            tick(1);
            chk(count_value, 8'h03);
            chk(8'(done_seen - d0), 8'h01);
            chk({6'h00, counter_status}, 8'h03);
            fire(lst[i], 1'b0, 1);
            chk(count_value, (lst[i] == evc_pkg::SRC_FRAME_BEGIN) ? 8'h00 : 8'h03);
        end
    endtask

    // Line edges under each qualification, with long pulses.
    task automatic t_lines();
        logic [7:0] exp;
        evc_pkg::evc_source_type s;
        for (int l = 0; l < 2; l++) begin
            for (int e = 0; e < 3; e++) begin
                s = (l == 0) ? evc_pkg::SRC_INPUT_LINE_A : evc_pkg::SRC_INPUT_LINE_B;
                restart(s, evc_pkg::evc_edge_type'(e), evc_pkg::SRC_FRAME_BEGIN,
                        evc_pkg::SRC_OFF, 8'hC8);
                fire(s, 1'b1, 1);
                tick(5);
                fire(s, 1'b0, 1);
                fire(s, 1'b1, 1);
                exp = (e == 0) ? 8'h02 : ((e == 1) ? 8'h01 : 8'h03);
                chk(count_value, exp);
                fire(s, 1'b0, 1);
            end
        end
    endtask

    // The microsecond tick adds one every 40 cycles.
    task automatic t_tick();
        logic [7:0] v;
        int n;
        restart(evc_pkg::SRC_MICROSECOND_TICK, evc_pkg::EDGE_RISING, evc_pkg::SRC_FRAME_BEGIN,
                evc_pkg::SRC_OFF, 8'hC8);
        v = count_value;
        n = 0;
        while (count_value === v && n < 60) begin
            tick(1);
            n++;
        end
        if (n >= 60) begin
            chk(count_value, v + 8'h01);
        end else begin
            v = count_value;
            tick(39);
            chk(count_value, v);
            tick(1);
            chk(count_value, v + 8'h01);
        end
    endtask

    // Each clear source but the tick and own done clears, keeps the prior count and waits for a start.
    task automatic t_clear_loop();
        evc_pkg::evc_source_type inc;
        evc_pkg::evc_source_type st;
        for (int c = 1; c < 14; c++) begin
            if (c == 12) continue;
            inc = (c == 7) ? evc_pkg::SRC_ACCEPTED_TRIGGER : evc_pkg::SRC_REJECTED_TRIGGER;
            st = (c == 5) ? evc_pkg::SRC_EXPOSURE_FINISH : evc_pkg::SRC_FRAME_BEGIN;
            restart(inc, evc_pkg::EDGE_RISING, st, evc_pkg::evc_source_type'(c), 8'hC8);
            fire(inc, 1'b0, 2);
            fire(evc_pkg::evc_source_type'(c), 1'b1, 1);
            chk(count_value, 8'h00);
            chk(value_at_clear, 8'h02);
            chk({6'h00, counter_status}, 8'h01);
            fire(evc_pkg::evc_source_type'(c), 1'b0, 1);
        end
    endtask

    // Without a clear source only the command clears; own done clears too.
    task automatic t_cmd_and_self();
        restart(evc_pkg::SRC_REJECTED_TRIGGER, evc_pkg::EDGE_RISING, evc_pkg::SRC_FRAME_BEGIN,
                evc_pkg::SRC_OFF, 8'hC8);
        fire(evc_pkg::SRC_REJECTED_TRIGGER, 1'b0, 2);
        fire(evc_pkg::SRC_EXPOSURE_BEGIN, 1'b0, 1);
        chk(count_value, 8'h02);
        restart(evc_pkg::SRC_REJECTED_TRIGGER, evc_pkg::EDGE_RISING, evc_pkg::SRC_FRAME_BEGIN,
                evc_pkg::SRC_COUNTER_DONE, 8'h02);
        chk(value_at_clear, 8'h02);
        fire(evc_pkg::SRC_REJECTED_TRIGGER, 1'b0, 2);
        tick(3);
        chk(count_value, 8'h00);
        chk(value_at_clear, 8'h02);
        chk({6'h00, counter_status}, 8'h01);
        restart(evc_pkg::SRC_REJECTED_TRIGGER, evc_pkg::EDGE_RISING, evc_pkg::SRC_FRAME_BEGIN,
                evc_pkg::SRC_OFF, 8'h00);
        fire(evc_pkg::SRC_REJECTED_TRIGGER, 1'b0, 258);
        chk(count_value, 8'hFF);
        chk({6'h00, counter_status}, 8'h02);
    endtask

    // Main sequence: reset, scenarios, verdict.
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        tick(1);
        chk(count_value, 8'h00);
        chk({6'h00, counter_status}, 8'h00);
        t_off();
        t_inc_loop();
        t_lines();
        t_tick();
        t_clear_loop();
        t_cmd_and_self();
        results();
    end
endmodule // evc_counter_tb_top

`default_nettype wire
